// [hw/bpi_map.svh]
// Field positions, codes and timings of the backplane interface.
`ifndef BPI_MAP_SVH
`define BPI_MAP_SVH
// Bus widths and address fields.
`define BPI_BUS_W 16
`define BPI_ADDR_W 15
`define BPI_UNIT_MSB 14
`define BPI_UNIT_LSB 11
`define BPI_SLOT_MSB 10
`define BPI_SLOT_LSB 8
`define BPI_REG_MSB 7
`define BPI_REG_LSB 0
`define BPI_SLOTS 8
// Measurement command base and immediate control register.
`define BPI_MEAS_BASE 8'h80
`define BPI_IEX_CTRL_REG 8'h7f
`define BPI_IEX_ON_BIT 0
// Qualified cycles between data strobe and response.
`define BPI_CARD_RESPONSE_QUALS 2'h2
// Local clock period and normalize pulse width.
`define BPI_CLK_PERIOD_NS 100
`define BPI_NORM_PULSE_NS 1000
`define BPI_NORM_CYC ((`BPI_NORM_PULSE_NS + `BPI_CLK_PERIOD_NS - 1) / `BPI_CLK_PERIOD_NS)
`endif

// [hw/bpi_pkg.sv]
// Types shared by the backplane card bus interface modules.
package bpi_pkg;
    // Handshake sequencer states.
    typedef enum logic [2:0] {
        BPI_IDLE,
        BPI_ADDR,
        BPI_SEL,
        BPI_COUNT,
        BPI_CARD_RESPONSE
    } bpi_state_t;
    // Word to the user side.
    typedef struct packed {
        logic global_wr;
        logic [7:0] reg_addr;
        logic [15:0] data;
    } bpi_word_t;
endpackage

// [hw/bpi_word_if.sv]
// Valid/ready carrier from the sequencer to the buffer.
`timescale 1ns/100ps
`default_nettype none
interface bpi_word_if;
    import bpi_pkg::*;
    logic valid; // Word offered.
    logic ready; // Buffer has room.
    bpi_word_t word; // Offered word.
    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface
`default_nettype wire

// [hw/bpi_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module bpi_buf2
    import bpi_pkg::*;
(
    // Clocking.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Filling side.
    bpi_word_if.snk fill,
    // Draining side.
    output logic out_valid_out,
    output bpi_word_t out_word_out,
    input wire logic out_ready_in
);
    bpi_word_t slot [2]; // Storage, entry 0 is the head.
    logic [1:0] count; // Number of words held.
    logic push; // Word accepted this cycle.
    logic pop; // Word drained this cycle.

    assign push = fill.valid && (count != 2'h2);
    assign pop = out_ready_in && (count != 2'h0);
    // Full buffer makes the sequencer withhold its answer to a write.
    assign fill.ready = (count != 2'h2);
    assign out_word_out = slot[0];

    // Occupancy count; valid is its own flop so the output comes from a register.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            count <= 2'h0;
            out_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
            out_valid_out <= (count > 2'h1) || (count == 2'h1 && !pop) || push;
        end
    end

    // Shift storage; the head always sits in entry 0 so the output is a flop.
    always_ff @(posedge mclk_in) begin
        if (clk_en_in) begin
            if (pop) begin
                slot[0] <= slot[1];
            end
            if (push) begin
                slot[1'(count - {1'b0, pop})] <= fill.word;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/bpi_regmem.sv]
// Card register image with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module bpi_regmem #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // Clocking.
    input wire logic mclk_in,
    input wire logic clk_en_in,
    // Write port.
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    // Read port.
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [2**AW]; // Register image, contents undefined until written.

    // Write and registered read; a same-cycle read sees the old word.
    always_ff @(posedge mclk_in) begin
        if (clk_en_in) begin
            if (we_in) begin
                mem[waddr_in] <= wdata_in;
            end
            rdata_out <= mem[raddr_in];
        end
    end
endmodule
`default_nettype wire

// [hw/bpi_top.sv]
// Backplane interface: address demultiplex, slot decode and handshake.
`timescale 1ns/100ps
`default_nettype none
`include "bpi_map.svh"
// Functional notes
// - Normalize pulse at boot and request.
// - Matching interface decodes one enable.
// - Low byte latched as register address.
// - Enable rises when strobe drops.
// - Card takes address when idle.
// - Global write makes cards respond.
// - Response after two qualifiers.
// - Write data taken at qualified edge.
// - Enable holds until next strobe.
// - Read raises selected enable.
// - Read data with response.
// - Only measurements need a strobe.
// - Immediate strobe for enabled card.
// - Deferred command awaits execute strobe.
// - Immediate condition reverts at task end.
// - Broadcast executes pending commands together.
// - Deferred input sampled at execute.
// - Fifteen-bit address latch.
// - Decode only on unit match.
// - Logic steps on qualified edges; the sequencer and enables step on any enabled clock.
module bpi_top
    import bpi_pkg::*;
#(
    parameter int NORM_CYC = `BPI_NORM_CYC
) (
    // Clocking and reset.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Controller bus pins.
    input wire logic ctrl_normalize_request_in,
    input wire logic addr_strobe_in,
    input wire logic write_line_in,
    input wire logic data_strobe_in,
    input wire logic global_write_enable_in,
    input wire logic second_word_flag_in,
    input wire logic immediate_exec_in,
    input wire logic broadcast_exec_in,
    input wire logic sys_clk_2m_in,
    input wire logic cycle_qualifier_in,
    input wire logic [`BPI_BUS_W-1:0] card_data_bus_in,
    output logic [`BPI_BUS_W-1:0] card_data_bus_out,
    output logic card_data_bus_oe_out,
    output logic card_response_out,
    // Unit address switch.
    input wire logic [3:0] unit_switch_in,
    // Card backplane outputs.
    output logic normalize_pulse_out,
    output logic [`BPI_SLOTS-1:0] slot_enable_out,
    output logic [7:0] card_reg_addr_out,
    // Written words toward the card function logic.
    output logic wr_valid_out,
    output bpi_word_t wr_word_out,
    input wire logic wr_ready_in,
    // Measurement execution toward the card function logic.
    output logic meas_exec_out,
    output logic [7:0] meas_addr_out,
    input wire logic [`BPI_BUS_W-1:0] meas_sample_in
);
    localparam int PW = 11 + `BPI_BUS_W + 4; // Synchronised pin group width.

    // Measurement command decode.
    function automatic logic is_meas(input logic [7:0] ra);
        is_meas = (ra >= `BPI_MEAS_BASE);
    endfunction

    logic [PW-1:0] pin_s1; // First synchroniser stage.
    logic [PW-1:0] pin_s2; // Second synchroniser stage.
    logic s_norm, s_ads, s_wrt, s_ds, s_glob, s_swt, s_iex, s_broadcast_exec, s_clk2m, s_cyc;
    logic [`BPI_BUS_W-1:0] s_bus; // Synchronised bus data.
    logic [3:0] s_unit; // Synchronised unit switch.
    logic ads_q; // Previous address strobe.
    logic clk2m_q; // Previous 2 MHz level.
    logic norm_q; // Previous normalize request.
    logic qual; // Active qualified 2 MHz edge.
    logic init; // Initial state held.
    logic [$clog2(NORM_CYC+1)-1:0] norm_cnt; // Pulse length count.
    logic boot_done; // Power-up pulse already issued.
    bpi_state_t state; // Handshake sequencer state.
    logic [`BPI_ADDR_W-1:0] addr_latch; // Current fifteen-bit address.
    logic engaged; // Cycle claimed.
    logic glob_cyc; // Current cycle is a global write.
    logic wr_op; // Data phase is a write.
    logic [1:0] qcnt; // Qualifiers counted.
    logic captured; // Word already taken.
    logic iex_hold; // Immediate execution commanded off.
    logic iex_smp; // Immediate strobe at last enabled qualifier.
    logic pending; // Deferred measurement waiting.
    logic [7:0] pend_addr; // Deferred address.
    logic samp_pend; // Sample write-back waiting.
    logic [7:0] samp_addr; // Sample register.
    logic [`BPI_BUS_W-1:0] samp_data; // Captured sample.
    logic [`BPI_BUS_W-1:0] rdata; // Register image read data.
    logic cap; // Write capture this cycle.
    logic exec_now; // Immediate execution.
    logic exec_bc; // Broadcast execution.
    logic mem_we; // Register image write.
    logic [7:0] mem_waddr; // Register image write address.
    logic [`BPI_BUS_W-1:0] mem_wdata; // Register image write data.
    logic buf_ready; // Buffer has room.
    bpi_word_if push_if (); // Sequencer-to-buffer carrier.

    // Pins are asynchronous, so each passes two flops.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (clk_en_in) begin
            pin_s1 <= {ctrl_normalize_request_in, addr_strobe_in, write_line_in,
                       data_strobe_in, global_write_enable_in, second_word_flag_in,
                       immediate_exec_in, broadcast_exec_in, sys_clk_2m_in,
                       cycle_qualifier_in, 1'b0, card_data_bus_in, unit_switch_in};
            pin_s2 <= pin_s1;
        end
    end
    assign {s_norm, s_ads, s_wrt, s_ds, s_glob, s_swt, s_iex, s_broadcast_exec, s_clk2m, s_cyc} =
        pin_s2[PW-1:PW-10];
    assign s_bus = pin_s2[`BPI_BUS_W+3:4];
    assign s_unit = pin_s2[3:0];

    // Strobe edge history.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ads_q <= 1'b0;
            clk2m_q <= 1'b0;
            norm_q <= 1'b0;
        end else if (clk_en_in) begin
            ads_q <= s_ads;
            clk2m_q <= s_clk2m;
            norm_q <= s_norm;
        end
    end
    assign qual = s_clk2m && !clk2m_q && s_cyc;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            norm_cnt <= '0;
            boot_done <= 1'b0;
            normalize_pulse_out <= 1'b0;
        end else if (clk_en_in) begin
            if (!boot_done || (s_norm && !norm_q)) begin
                boot_done <= 1'b1;
                norm_cnt <= ($bits(norm_cnt))'(NORM_CYC - 1);
                normalize_pulse_out <= 1'b1;
            end else if (norm_cnt != '0) begin
                norm_cnt <= norm_cnt - 1'b1;
            end else begin
                normalize_pulse_out <= 1'b0;
            end
        end
    end
    // Initial state holds for the whole pulse.
    assign init = normalize_pulse_out;

    // Capture and execute decisions.
    assign cap = (state == BPI_CARD_RESPONSE) && wr_op && qual && !captured;
    assign exec_now = cap && is_meas(addr_latch[7:0]) && !glob_cyc && iex_smp && !iex_hold;
    assign exec_bc = qual && s_broadcast_exec && pending;

    // Handshake sequencer.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || init) begin
            state <= BPI_IDLE;
            addr_latch <= '0;
            engaged <= 1'b0;
            glob_cyc <= 1'b0;
            wr_op <= 1'b0;
            qcnt <= 2'h0;
            captured <= 1'b0;
        end else if (clk_en_in) begin
            if (s_ads && !ads_q) begin
                // A new address strobe ends any cycle in progress.
                state <= BPI_ADDR;
                engaged <= 1'b0;
            end else begin
                unique case (state)
                    BPI_IDLE: begin
                        state <= BPI_IDLE;
                    end
                    BPI_ADDR: begin
                        if (s_ads) begin
                            // fifteen-bit address latch follows the bus.
                            addr_latch <= s_bus[`BPI_ADDR_W-1:0];
                        end else begin
                            // unit match or global write claims it.
                            engaged <= (addr_latch[`BPI_UNIT_MSB:`BPI_UNIT_LSB] == s_unit)
                                       || s_glob;
                            glob_cyc <= s_glob;
                            state <= BPI_SEL;
                        end
                    end
                    BPI_SEL: begin
                        // a second word reuses the held address and enable.
                        if (s_ds && engaged) begin
                            wr_op <= s_wrt;
                            qcnt <= 2'h0;
                            captured <= 1'b0;
                            state <= BPI_COUNT;
                        end
                    end
                    BPI_COUNT: begin
                        if (!s_ds) begin
                            state <= BPI_SEL;
                        end else if (qcnt == `BPI_CARD_RESPONSE_QUALS) begin
                            // a write waits for buffer room.
                            if (!wr_op || buf_ready) begin
                                state <= BPI_CARD_RESPONSE;
                            end
                        end else if (qual) begin
                            qcnt <= qcnt + 2'h1;
                        end
                    end
                    BPI_CARD_RESPONSE: begin
                        if (cap) begin
                            captured <= 1'b1;
                        end
                        if (!s_ds) begin
                            state <= BPI_SEL;
                        end
                    end
                endcase
            end
        end
    end

    // Slot enables toward the cards.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || init) begin
            slot_enable_out <= '0;
        end else if (clk_en_in) begin
            if (s_ads && !ads_q) begin
                // enables drop at the next address strobe.
                slot_enable_out <= '0;
            end else if (state == BPI_ADDR && !s_ads &&
                         addr_latch[`BPI_UNIT_MSB:`BPI_UNIT_LSB] == s_unit) begin
                // one-hot enable as the strobe drops.
                slot_enable_out <= `BPI_SLOTS'(1) << addr_latch[`BPI_SLOT_MSB:`BPI_SLOT_LSB];
            end
        end
    end

    // Card register address and immediate strobe.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || init) begin
            card_reg_addr_out <= '0;
            iex_smp <= 1'b0;
        end else if (clk_en_in) begin
            if (qual && (state == BPI_SEL || state == BPI_COUNT) && engaged) begin
                // new address once the sample is stored.
                if (!samp_pend) begin
                    // low byte of the address phase goes to the cards.
                    card_reg_addr_out <= addr_latch[`BPI_REG_MSB:`BPI_REG_LSB];
                end
                // only the enabled card sees it.
                iex_smp <= s_iex;
            end
        end
    end

    // Response and read data drive.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || init) begin
            card_response_out <= 1'b0;
            card_data_bus_oe_out <= 1'b0;
            card_data_bus_out <= '0;
        end else if (clk_en_in) begin
            if (state == BPI_COUNT && s_ds && qcnt == `BPI_CARD_RESPONSE_QUALS &&
                (!wr_op || buf_ready)) begin
                card_response_out <= 1'b1;
                card_data_bus_oe_out <= !wr_op;
                card_data_bus_out <= rdata;
            end else if (state != BPI_CARD_RESPONSE || !s_ds) begin
                card_response_out <= 1'b0;
                card_data_bus_oe_out <= 1'b0;
            end
        end
    end

    // Measurement command bookkeeping.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || init) begin
            iex_hold <= 1'b0;
            pending <= 1'b0;
            pend_addr <= '0;
            meas_exec_out <= 1'b0;
            meas_addr_out <= '0;
        end else if (clk_en_in) begin
            meas_exec_out <= 1'b0;
            if (exec_now) begin
                meas_exec_out <= 1'b1;
                meas_addr_out <= addr_latch[7:0];
                pending <= 1'b0;
            end else if (exec_bc) begin
                meas_exec_out <= 1'b1;
                meas_addr_out <= pend_addr;
                pending <= 1'b0;
                // end of task restores immediate execution.
                iex_hold <= 1'b0;
            end
            if (cap && is_meas(addr_latch[7:0]) && !exec_now) begin
                // deferred command is held; it wins over a same-cycle broadcast.
                pending <= 1'b1;
                pend_addr <= addr_latch[7:0];
            end
            if (cap && addr_latch[7:0] == `BPI_IEX_CTRL_REG) begin
                iex_hold <= !push_if.word.data[`BPI_IEX_ON_BIT];
            end
        end
    end

    // sample written back for a later read.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || init) begin
            samp_pend <= 1'b0;
            samp_addr <= '0;
            samp_data <= '0;
        end else if (clk_en_in) begin
            if (exec_now || exec_bc) begin
                samp_pend <= 1'b1;
                samp_addr <= exec_now ? addr_latch[7:0] : pend_addr;
                samp_data <= meas_sample_in;
            end else if (!cap) begin
                samp_pend <= 1'b0;
            end
        end
    end

    // write data taken at the qualified edge.
    assign push_if.valid = cap;
    assign push_if.word = '{global_wr: glob_cyc, reg_addr: addr_latch[7:0], data: s_bus};
    assign buf_ready = push_if.ready;
    // configuration words are stored at once; captures beat sample write-back.
    assign mem_we = cap || samp_pend;
    assign mem_waddr = cap ? addr_latch[7:0] : samp_addr;
    assign mem_wdata = cap ? s_bus : samp_data;

    // Register image of the card.
    bpi_regmem #(
        .AW(8),
        .DW(`BPI_BUS_W)
    ) u_regmem (
        .mclk_in(mclk_in),
        .clk_en_in(clk_en_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(addr_latch[7:0]),
        .rdata_out(rdata)
    );

    // Two-entry buffer to the card logic.
    bpi_buf2 u_buf (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .fill(push_if.snk),
        .out_valid_out(wr_valid_out),
        .out_word_out(wr_word_out),
        .out_ready_in(wr_ready_in)
    );
endmodule
`default_nettype wire

// [dv/bpi_top_asserts.sv]
// Port checks for the backplane interface top.
`timescale 1ns/100ps
`default_nettype none
`include "bpi_map.svh"
module bpi_top_asserts
    import bpi_pkg::*;
#(
    parameter int NORM_CYC = 10
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Watched pins.
    input wire logic addr_strobe_in,
    input wire logic data_strobe_in,
    input wire logic wr_ready_in,
    input wire logic [`BPI_BUS_W-1:0] card_data_bus_out,
    input wire logic card_data_bus_oe_out,
    input wire logic card_response_out,
    input wire logic normalize_pulse_out,
    input wire logic [`BPI_SLOTS-1:0] slot_enable_out,
    input wire logic wr_valid_out,
    input wire bpi_word_t wr_word_out,
    input wire logic meas_exec_out
);
    // Pulse length count; a repetition cannot take a parameter.
    int norm_cnt;
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || !normalize_pulse_out) begin
            norm_cnt <= 0;
        end else begin
            norm_cnt <= norm_cnt + 1;
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    norm_width_a: assert property ($fell(normalize_pulse_out) |-> norm_cnt == NORM_CYC)
        else $error("pulse width");
    enable_onehot_a: assert property ($onehot0(slot_enable_out))
        else $error("two enables");
    enable_set_a: assert property (($changed(slot_enable_out) && slot_enable_out != 8'h00)
        |-> !$past(addr_strobe_in) && !$past(addr_strobe_in, 2)) else $error("enable early");
    enable_clear_a: assert property ($rose(addr_strobe_in) |-> ##[1:4] slot_enable_out == 8'h00)
        else $error("enable stuck");
    enable_hold_a: assert property ($fell(|slot_enable_out) |-> normalize_pulse_out
        || $past(addr_strobe_in, 2) || $past(addr_strobe_in, 4)) else $error("enable dropped");
    card_response_cause_a: assert property ($rose(card_response_out) |-> $past(data_strobe_in, 2))
        else $error("stray response");
    card_response_drop_a: assert property ($fell(data_strobe_in) |-> ##[1:4] !card_response_out)
        else $error("response stuck");
    oe_card_response_a: assert property (card_data_bus_oe_out |-> card_response_out)
        else $error("data without response");
    read_stable_a: assert property (card_data_bus_oe_out && $past(card_data_bus_oe_out)
        |-> $stable(card_data_bus_out)) else $error("read data moved");
    word_hold_a: assert property (wr_valid_out && !wr_ready_in
        |=> wr_valid_out && $stable(wr_word_out)) else $error("word lost");
    exec_pulse_a: assert property (meas_exec_out |=> !meas_exec_out)
        else $error("long pulse");
endmodule
bind bpi_top bpi_top_asserts #(
    .NORM_CYC(NORM_CYC)
) bpi_top_asserts_inst (
    .mclk_in, .rst_n_in, .addr_strobe_in, .data_strobe_in, .wr_ready_in, .card_data_bus_out,
    .card_data_bus_oe_out, .card_response_out, .normalize_pulse_out, .slot_enable_out,
    .wr_valid_out, .wr_word_out, .meas_exec_out
);
`default_nettype wire

// [dv/bpi_ctrl_model.sv]
// Behavioural controller card driving the multiplexed backplane bus.
`timescale 1ns/100ps
`default_nettype none
module bpi_ctrl_model (
    // Clock and card answer.
    input wire logic mclk_in,
    input wire logic card_response_in,
    input wire logic [15:0] card_data_bus_in,
    // Controller pins.
    output logic addr_strobe_out,
    output logic write_line_out,
    output logic data_strobe_out,
    output logic global_write_enable_out,
    output logic sys_clk_2m_out,
    output logic cycle_qualifier_out,
    output logic [15:0] card_data_bus_out
);
    logic [2:0] phase = 3'h0; // Step in the 2 MHz period.
    initial begin
        addr_strobe_out = 1'b0;
        write_line_out = 1'b1;
        data_strobe_out = 1'b0;
        global_write_enable_out = 1'b0;
        sys_clk_2m_out = 1'b0;
        card_data_bus_out = 16'h0000;
    end
    always @(negedge mclk_in) begin
        phase <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
        sys_clk_2m_out <= (phase < 3'h2);
    end
    assign cycle_qualifier_out = 1'b1;
    // One transfer; a released bus shows the inverse.
    task automatic xfer(input logic wr, input logic glob, input logic [15:0] addr,
        input logic [15:0] wdata, output logic ok, output logic [15:0] rdata);
        ok = 1'b0;
        rdata = 16'h0000;
        @(negedge mclk_in);
        addr_strobe_out = 1'b1;
        write_line_out = 1'b1;
        card_data_bus_out = addr;
        global_write_enable_out = glob;
        repeat (20) @(negedge mclk_in);
        addr_strobe_out = 1'b0;
        data_strobe_out = 1'b1;
        write_line_out = wr;
        card_data_bus_out = wr ? wdata : ~addr;
        for (int i = 0; i < 400 && !ok; i++) begin
            @(posedge mclk_in);
            ok = card_response_in;
            rdata = card_data_bus_in;
        end
        repeat (6) @(negedge mclk_in);
        data_strobe_out = 1'b0;
        global_write_enable_out = 1'b0;
        card_data_bus_out = ~card_data_bus_out;
        repeat (5) @(negedge mclk_in);
    endtask
endmodule
`default_nettype wire

// [dv/tb_backplane_card_bus_handshake.sv]
// Self-checking bench for the backplane interface top.
`timescale 1ns/100ps
`default_nettype none
module tb_backplane_card_bus_handshake;
    import bpi_pkg::*;
    localparam int NORM = 2;
    localparam logic [3:0] UNIT = 4'h5;
    localparam logic [15:0] SAMPLE = 16'h5a3c;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic nreq = 1'b0;
    logic imm = 1'b1;
    logic bcast = 1'b0;
    logic rdy = 1'b1;
    logic addr_strobe, write_line, data_strobe, gwe, sclk, cq, oe, card_response, nrm, wv, mx, ok;
    logic [15:0] bus_i, bus_o, rd;
    logic [7:0] en, ra, ma;
    bpi_word_t ww, last_w;
    int error_cnt = 0;
    int checks = 0;
    int execs = 0;
    int words = 0;
    always #50 mclk_in = ~mclk_in;
    bpi_top #(.NORM_CYC(NORM)) bpi_top_inst (.mclk_in, .rst_n_in,
        .clk_en_in(1'b1), .ctrl_normalize_request_in(nreq), .addr_strobe_in(addr_strobe),
        .write_line_in(write_line), .data_strobe_in(data_strobe), .global_write_enable_in(gwe),
        .second_word_flag_in(1'b0), .immediate_exec_in(imm), .broadcast_exec_in(bcast),
        .sys_clk_2m_in(sclk), .cycle_qualifier_in(cq), .card_data_bus_in(bus_i),
        .card_data_bus_out(bus_o), .card_data_bus_oe_out(oe), .card_response_out(card_response),
        .unit_switch_in(UNIT), .normalize_pulse_out(nrm), .slot_enable_out(en),
        .card_reg_addr_out(ra), .wr_valid_out(wv), .wr_word_out(ww), .wr_ready_in(rdy),
        .meas_exec_out(mx), .meas_addr_out(ma), .meas_sample_in(SAMPLE));
    bpi_ctrl_model bpi_ctrl_model_inst (.mclk_in(mclk_in), .card_response_in(card_response),
        .card_data_bus_in(bus_o), .addr_strobe_out(addr_strobe), .write_line_out(write_line),
        .data_strobe_out(data_strobe), .global_write_enable_out(gwe), .sys_clk_2m_out(sclk),
        .cycle_qualifier_out(cq), .card_data_bus_out(bus_i));
    // Drained words and execute pulses.
    always @(posedge mclk_in) begin
        if (wv === 1'b1 && rdy === 1'b1) begin
            words++;
            last_w = ww;
        end
        execs += int'(mx === 1'b1);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic xw(input logic [3:0] u, input logic [2:0] s, input logic [7:0] r,
        input logic [15:0] d, input logic g);
        bpi_ctrl_model_inst.xfer(1'b1, g, {1'b0, u, s, r}, d, ok, rd);
    endtask
    task automatic t_main();
        int n;
        nreq = 1'b1;
        repeat (2) @(negedge mclk_in);
        nreq = 1'b0;
        n = 0;
        repeat (20) begin
            @(negedge mclk_in);
            n += int'(nrm === 1'b1);
        end
        chk(n, NORM);
        for (int s = 0; s < 8; s++) begin
            xw(UNIT, s[2:0], 8'h10 + s[7:0], 16'ha500 + s[15:0], 1'b0);
            chk(ok, 1'b1);
            chk(en, 8'h01 << s);
            chk(ra, 8'h10 + s[7:0]);
            chk(last_w, {1'b0, 8'h10 + s[7:0], 16'ha500 + s[15:0]});
        end
        xw(4'h3, 3'h2, 8'h20, 16'h1234, 1'b0);
        chk({ok, en}, 9'h000);
        xw(4'h3, 3'h2, 8'h21, 16'h4321, 1'b1);
        chk({ok, en}, 9'h100);
        chk(last_w, {1'b1, 8'h21, 16'h4321});
        $display("unit test done");
    endtask
    task automatic t_stall();
        int n;
        rdy = 1'b0;
        n = words;
        xw(UNIT, 3'h1, 8'h30, 16'h0001, 1'b0);
        xw(UNIT, 3'h1, 8'h31, 16'h0002, 1'b0);
        fork
            xw(UNIT, 3'h1, 8'h32, 16'h0003, 1'b0);
            begin
                repeat (150) @(negedge mclk_in);
                chk(card_response, 1'b0);
                rdy = 1'b1;
            end
        join
        chk(ok, 1'b1);
        chk(words - n, 3);
        chk(last_w, {1'b0, 8'h32, 16'h0003});
        $display("stall test done");
    endtask
    task automatic t_meas();
        int n;
        n = execs;
        xw(UNIT, 3'h4, 8'h85, 16'h0000, 1'b0);
        chk(execs - n, 1);
        chk(ma, 8'h85);
        imm = 1'b0;
        xw(UNIT, 3'h4, 8'h86, 16'h0000, 1'b0);
        chk(execs - n, 1);
        bcast = 1'b1;
        repeat (10) @(negedge mclk_in);
        bcast = 1'b0;
        repeat (5) @(negedge mclk_in);
        chk(execs - n, 2);
        chk(ma, 8'h86);
        imm = 1'b1;
        bpi_ctrl_model_inst.xfer(1'b0, 1'b0, {1'b0, UNIT, 3'h4, 8'h86}, 16'h0000, ok, rd);
        chk({ok, rd}, {1'b1, SAMPLE});
        $display("measure test done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (14) @(negedge mclk_in);
        t_main();
        t_stall();
        t_meas();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
`default_nettype wire
